// File: hw/quadword_reference_accel_ctrl.sv
// Quadword reference splitter and accelerator control/status register.
//
// Contract
// RULE1: Bad-parity bit set forces inverted parity on all writes and operand transfers.
// RULE2: Reading control register clears bad-parity bit; that bit reads back zero.
// RULE3: Interrupt, exception or console halt start clears bad-parity state first.
// RULE4: Reset clears the bad-parity enable bit.
// RULE5: Register reads return zero in bits 30 to 2 and bit 0.
// RULE6: Coprocessor enabled sends float and longword multiply to the coprocessor.
// RULE7: Coprocessor disabled makes float instructions raise reserved instruction fault.
// RULE8: Reset clears the coprocessor-enable bit.
// RULE9: Software sets bad-parity bit only for diagnostics.
// RULE10: Software keeps coprocessor enabled normally, may clear after coprocessor error.
// RULE11: Empty prefetch queue longword slot triggers aligned quadword fetch unless halted.
// RULE12: Operand, page table, control block fetches issue demand data reads.
// RULE13: Interlocked instructions issue read-lock references instead of plain reads.
// RULE14: Byte, contained word or aligned quadword read gives one quadword read.
// RULE15: Straddling word or unaligned quadword read gives two quadword reads.
// RULE16: Larger reads split into consecutive quadword reads without merging.
// RULE17: Byte, contained word or aligned quadword store gives one quadword write.
// RULE18: Straddling word or unaligned quadword store gives two quadword writes.
// RULE19: Larger stores split into consecutive quadword writes.
// RULE20: Every reference is an aligned quadword flagged masked or unmasked.
// RULE21: Any alignment accepted except interlocked add and queue operands.
// RULE22: Coprocessor path covers three float formats, byte, word, longword conversions.
// RULE23: Split references go in ascending order, next only after previous accepted.
// RULE24: Masked references carry byte enables covering exactly the operand bytes.
`timescale 1ns/10ps
`include "qref_cfg.svh"

module quadword_reference_accel_ctrl (
    // Clock and reset.
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // Processor register access.
    input  wire logic                 preg_wr,
    input  wire logic                 preg_rd,
    input  wire logic [7:0]           preg_addr,
    input  wire logic [31:0]          preg_wdata,
    output logic      [31:0]          preg_rdata,
    output logic                      preg_rvalid,
    // Trap events.
    input  wire logic                 trap_start,
    // Instruction dispatch.
    input  wire logic                 instr_valid,
    input  wire qref_pkg::opc_class_e instr_class,
    output logic                      coproc_dispatch,
    output logic                      mull_microcode,
    output logic                      resv_instr_fault,
    // Prefetch queue.
    input  wire logic [2:0]           pq_used,
    input  wire logic                 pq_halted,
    // Data operand requests.
    input  wire logic                 op_valid,
    input  wire logic                 op_write,
    input  wire logic                 op_interlock,
    input  wire logic                 op_aligned_only,
    input  wire qref_pkg::dsrc_e      op_src,
    input  wire logic [31:0]          op_addr,
    input  wire logic [7:0]           op_len,
    output logic                      op_ready,
    output logic                      align_fault,
    // Quadword references toward cache and memory.
    output logic                      ref_valid,
    output qref_pkg::ref_kind_e       ref_kind,
    output logic [31:0]               ref_addr,
    output logic [7:0]                ref_byte_en,
    output logic                      ref_masked,
    output logic                      ref_bad_parity,
    input  wire logic                 ref_accept,
    // Coprocessor operand transfers.
    input  wire logic                 coproc_xfer,
    output logic                      coproc_bad_parity
);
    import qref_pkg::*;

    // ==========================================================
    // Control register
    // ==========================================================
    logic        bad_par_reg;
    logic        fpu_en_reg;
    logic        acc_hit;

    assign acc_hit = (preg_addr == `ACC_CTRL_OFFSET);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bad_par_reg <= `ACC_CTRL_BAD_PAR_RST; // RULE4
        end else if (trap_start) begin
            bad_par_reg <= 1'b0; // RULE3
        end else if (preg_rd && acc_hit) begin
            bad_par_reg <= 1'b0; // RULE2
        end else if (preg_wr && acc_hit) begin
            bad_par_reg <= preg_wdata[`ACC_CTRL_BAD_PAR_BIT];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fpu_en_reg <= `ACC_CTRL_FPU_EN_RST; // RULE8
        end else if (preg_wr && acc_hit) begin
            fpu_en_reg <= preg_wdata[`ACC_CTRL_FPU_EN_BIT];
        end
    end

    // Bad-parity bit is write only, so reads show only the enable bit.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            preg_rdata  <= 32'h0000_0000;
            preg_rvalid <= 1'b0;
        end else begin
            preg_rvalid <= preg_rd;
            preg_rdata  <= 32'h0000_0000; // RULE5
            if (preg_rd && acc_hit) begin
                preg_rdata[`ACC_CTRL_FPU_EN_BIT] <= fpu_en_reg; // RULE5
            end
        end
    end

    // ==========================================================
    // Instruction dispatch
    // ==========================================================
    // Float class covers F, D and G formats and byte, word and
    // longword conversions; the decoder reports them as one class.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            coproc_dispatch <= 1'b0;
        end else begin
            coproc_dispatch <= instr_valid && fpu_en_reg &&
                               (instr_class == OPC_FLOAT ||
                                instr_class == OPC_MULL); // RULE6 RULE22
        end
    end

    // With the coprocessor off, longword multiply falls back to microcode.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mull_microcode <= 1'b0;
        end else begin
            mull_microcode <= instr_valid && !fpu_en_reg &&
                              instr_class == OPC_MULL;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resv_instr_fault <= 1'b0;
        end else begin
            resv_instr_fault <= instr_valid && !fpu_en_reg &&
                                instr_class == OPC_FLOAT; // RULE7
        end
    end

    // ==========================================================
    // Byte enables for one quadword
    // ==========================================================
    function automatic logic [7:0] qw_mask(input logic [31:0] first,
                                           input logic [31:0] last,
                                           input logic [31:0] base);
        logic [7:0] m;
        logic [31:0] b;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            b = base + 32'(i);
            m[i] = (b >= first) && (b <= last);
        end
        return m;
    endfunction : qw_mask

    // ==========================================================
    // Reference sequencer
    // ==========================================================
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DATA,
        ST_FETCH
    } seq_e;

    seq_e        state_reg;
    logic [31:0] cur_qw_reg;
    logic [31:0] first_reg;
    logic [31:0] last_reg;
    ref_kind_e   kind_reg;
    logic [31:0] fetch_addr_reg;
    logic        pq_empty_slot;
    logic        bad_align;
    logic [31:0] op_last;
    logic [7:0]  mask_now;

    assign pq_empty_slot = (pq_used < `PQ_SLOTS) && !pq_halted; // RULE11
    assign op_last   = op_addr + 32'(op_len) - 32'h1;
    assign bad_align = op_aligned_only &&
                       ((op_addr & (32'(op_len) - 32'h1)) != 32'h0); // RULE21
    assign mask_now  = qw_mask(first_reg, last_reg, cur_qw_reg);

    // ==========================================================
    // Request decode
    // ==========================================================
    logic        op_live;
    logic        take_fault;
    logic        take_op;
    logic        take_fetch;
    logic        data_issue;
    logic        data_accept;
    logic        last_qw;
    logic        fetch_accept;

    // Demand data takes priority over prefetch in the idle state.
    assign op_live      = op_valid && (op_len != 8'h00);
    assign take_fault   = (state_reg == ST_IDLE) && op_live && bad_align;
    assign take_op      = (state_reg == ST_IDLE) && op_live && !bad_align;
    assign take_fetch   = (state_reg == ST_IDLE) && !op_live && pq_empty_slot;
    assign data_issue   = (state_reg == ST_DATA) && !ref_valid;
    assign data_accept  = (state_reg == ST_DATA) && ref_valid && ref_accept;
    assign last_qw      = (cur_qw_reg[31:3] == last_reg[31:3]);
    assign fetch_accept = (state_reg == ST_FETCH) && ref_accept;

    // ==========================================================
    // Sequencer state
    // ==========================================================
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (take_op) begin
                        state_reg <= ST_DATA;
                    end else if (take_fetch) begin
                        state_reg <= ST_FETCH;
                    end
                end
                ST_DATA: begin
                    // Next quadword only after the current one is taken.
                    if (data_accept && last_qw) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_FETCH: begin
                    if (fetch_accept) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Operand window and the quadword now being referenced.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur_qw_reg <= 32'h0000_0000;
            first_reg  <= 32'h0000_0000;
            last_reg   <= 32'h0000_0000;
            kind_reg   <= REF_DREAD;
        end else if (take_op) begin
            // All data sources (operand, page table entry, control
            // blocks) issue demand reads.
            first_reg  <= op_addr; // RULE12
            last_reg   <= op_last;
            cur_qw_reg <= {op_addr[31:3], 3'h0}; // RULE20
            if (op_write) begin
                kind_reg <= REF_WRITE;
            end else if (op_interlock) begin
                kind_reg <= REF_DREAD_LOCK; // RULE13
            end else begin
                kind_reg <= REF_DREAD;
            end
        end else if (data_accept && !last_qw) begin // RULE18 RULE19 RULE23
            cur_qw_reg <= cur_qw_reg + 32'(`QW_BYTES); // RULE15 RULE16
        end
    end

    // Completion pulse, raised together with align_fault for a refused aligned-only operand.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            op_ready    <= 1'b0;
            align_fault <= 1'b0;
        end else begin
            align_fault <= take_fault; // RULE21
            op_ready    <= take_fault ||
                           (data_accept && last_qw); // RULE14 RULE17
        end
    end

    // ==========================================================
    // Reference outputs
    // ==========================================================
    // Outputs hold steady until the far side accepts the reference.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ref_valid   <= 1'b0;
            ref_kind    <= REF_ISTREAM;
            ref_addr    <= 32'h0000_0000;
            ref_byte_en <= 8'h00;
            ref_masked  <= 1'b0;
        end else if (take_fetch) begin
            ref_valid   <= 1'b1;
            ref_kind    <= REF_ISTREAM; // RULE11
            ref_addr    <= fetch_addr_reg;
            ref_byte_en <= 8'hff;
            ref_masked  <= 1'b0;
        end else if (data_issue) begin
            ref_valid   <= 1'b1;
            ref_kind    <= kind_reg;
            ref_addr    <= cur_qw_reg; // RULE20
            ref_byte_en <= mask_now; // RULE24
            ref_masked  <= (mask_now != 8'hff); // RULE20
        end else if (data_accept || fetch_accept ||
                     (state_reg != ST_DATA && state_reg != ST_FETCH)) begin
            ref_valid   <= 1'b0;
        end
    end

    // Prefetch address advances one quadword per accepted fetch.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fetch_addr_reg <= 32'h0000_0000;
        end else if (fetch_accept) begin
            fetch_addr_reg <= fetch_addr_reg + 32'(`QW_BYTES);
        end
    end

    // ==========================================================
    // Parity corruption
    // ==========================================================
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ref_bad_parity <= 1'b0;
        end else begin
            ref_bad_parity <= bad_par_reg && !trap_start; // RULE1 RULE3
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            coproc_bad_parity <= 1'b0;
        end else begin
            coproc_bad_parity <= bad_par_reg && !trap_start &&
                                 coproc_xfer; // RULE1
        end
    end

endmodule : quadword_reference_accel_ctrl

// File: hw/qref_cfg.svh
// Offsets, field positions, reset values and sizes for the quadword reference block.
`ifndef QREF_CFG_SVH
`define QREF_CFG_SVH
`define ACC_CTRL_OFFSET        8'h28
`define ACC_CTRL_BAD_PAR_BIT   31
`define ACC_CTRL_FPU_EN_BIT    1
`define ACC_CTRL_BAD_PAR_RST   1'b0
`define ACC_CTRL_FPU_EN_RST    1'b0
`define PQ_SLOTS           3'h4
`define QW_BYTES           4'h8
`endif

// File: hw/qref_pkg.sv
// Types shared by the quadword reference block.
package qref_pkg;
    typedef enum logic [1:0] {
        REF_ISTREAM,
        REF_DREAD,
        REF_DREAD_LOCK,
        REF_WRITE
    } ref_kind_e;
    typedef enum logic [1:0] {
        OPC_OTHER,
        OPC_FLOAT,
        OPC_MULL
    } opc_class_e;
    typedef enum logic [1:0] {
        DSRC_OPERAND,
        DSRC_PAGE_TABLE_ENTRY,
        DSRC_SYSTEM_CONTROL_BLOCK,
        DSRC_PROCESS_CONTROL_BLOCK
    } dsrc_e;
endpackage : qref_pkg

// File: tb/qref_checker.sv
// Assertion checker bound to the quadword reference block.
`timescale 1ns/10ps
module qref_checker import qref_pkg::*; (
    // All watched ports of the block.
    input wire logic        sys_clk, rst, preg_wr, preg_rd, preg_rvalid,
    input wire logic [7:0]  preg_addr, ref_byte_en,
    input wire logic [31:0] preg_wdata, preg_rdata, ref_addr,
    input wire logic        trap_start, instr_valid, coproc_dispatch,
    input wire opc_class_e  instr_class,
    input wire logic        resv_instr_fault, op_ready, align_fault,
    input wire logic        ref_valid, ref_masked, ref_accept,
    input wire ref_kind_e   ref_kind,
    input wire logic        ref_bad_parity, coproc_xfer, coproc_bad_parity
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_READ_ANSWER: assert property (preg_rd && preg_addr == 8'h28 |=>
        preg_rvalid && preg_rdata[31:2] == 30'h0 && !preg_rdata[0])
        else $error("control read answer wrong");
    AST_READ_CLEARS: assert property (preg_rd && preg_addr == 8'h28
        |=> ##1 !ref_bad_parity) else $error("read left bad parity on");
    AST_TRAP_CLEARS: assert property (trap_start |=> !ref_bad_parity)
        else $error("trap left bad parity on");
    AST_BAD_CAUSE: assert property ($rose(ref_bad_parity) |->
        $past(preg_wr, 2) && $past(preg_addr, 2) == 8'h28
        && $past(preg_wdata[31], 2)) else $error("bad parity uncaused");
    AST_COPROC_PARITY: assert property (coproc_bad_parity |->
        $past(coproc_xfer)) else $error("operand bad parity without transfer");
    AST_FLOAT_ROUTE: assert property (instr_valid
        && instr_class == OPC_FLOAT |=> coproc_dispatch != resv_instr_fault)
        else $error("float instruction misrouted");
    AST_OTHER_STAYS: assert property (instr_valid
        && instr_class == OPC_OTHER |=> !coproc_dispatch && !resv_instr_fault)
        else $error("plain instruction dispatched");
    AST_REF_SHAPE: assert property (ref_valid |-> ref_addr[2:0] == 3'h0
        && ref_masked == (ref_byte_en != 8'hff)) else $error("bad ref shape");
    AST_REF_HOLD: assert property (ref_valid && !ref_accept |=> ref_valid
        && $stable(ref_addr) && $stable(ref_byte_en) && $stable(ref_kind))
        else $error("reference changed before accept");
    AST_ISTREAM_FULL: assert property (ref_valid
        && ref_kind == REF_ISTREAM |-> ref_byte_en == 8'hff)
        else $error("fetch not full quadword");
    AST_FAULT_DONE: assert property (align_fault |-> op_ready)
        else $error("align fault without completion");
    cover property (ref_valid && ref_accept && ref_kind == REF_WRITE);
    cover property (align_fault);
    cover property (resv_instr_fault);
endmodule : qref_checker

bind quadword_reference_accel_ctrl qref_checker chk_i (.*);

// File: tb/qref_mem_model.sv
// Cache and memory controller model that accepts quadword references.
`timescale 1ns/10ps
module qref_mem_model (
    // Clock, reset and reference handshake.
    input wire logic       sys_clk, rst, ref_valid,
    input wire logic [3:0] wait_cycles,
    output logic           ref_accept
);
    logic [3:0] wait_reg;

    // Counts stall cycles so each reference waits the set number.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wait_reg <= 4'h0;
        end else if (ref_valid && !ref_accept) begin
            wait_reg <= wait_reg + 4'h1;
        end else begin
            wait_reg <= 4'h0;
        end
    end
    assign ref_accept = ref_valid && (wait_reg == wait_cycles);
endmodule : qref_mem_model

// File: tb/test_quadword_reference_accel_ctrl.sv
// Self-checking bench for the quadword reference block.
`timescale 1ns/10ps
module test_quadword_reference_accel_ctrl;
    import qref_pkg::*;
    logic sys_clk, rst, preg_wr, preg_rd, preg_rvalid, trap_start;
    logic instr_valid, coproc_dispatch, mull_microcode, resv_instr_fault;
    logic pq_halted, op_valid, op_write, op_interlock, op_aligned_only;
    logic op_ready, align_fault, ref_valid, ref_masked, ref_bad_parity;
    logic ref_accept, coproc_xfer, coproc_bad_parity;
    logic [2:0]  pq_used;
    logic [3:0]  wait_cycles;
    logic [7:0]  preg_addr, op_len, ref_byte_en;
    logic [31:0] preg_wdata, preg_rdata, op_addr, ref_addr, rd;
    opc_class_e  instr_class;
    dsrc_e       op_src;
    ref_kind_e   ref_kind;
    logic [42:0] seen[$];
    int bad_count = 0, total_checks = 0, cycles = 0;

    quadword_reference_accel_ctrl dut (.*);
    qref_mem_model mem (.*);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Records every accepted reference and cuts a hang short.
    always @(posedge sys_clk) begin
        if (ref_valid && ref_accept) seen.push_back({ref_kind, ref_addr,
            ref_byte_en, ref_masked});
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            complete_run();
        end
    end

    // ==========================================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [42:0] ex, got);
        total_checks++;
        if (got !== ex) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        preg_addr = a; preg_wdata = d; preg_wr = 1'b1;
        tick(1);
        preg_wr = 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a);
        preg_addr = a; preg_rd = 1'b1;
        tick(1);
        preg_rd = 1'b0;
        rd = preg_rdata;
        chk("preg_rvalid", 1, preg_rvalid);
    endtask : reg_rd
    task automatic op(input logic w, lk, ao, input logic [31:0] a,
                      input logic [7:0] n);
        logic [31:0] q;
        logic [7:0]  en;
        ref_kind_e   k;
        int          i, b;
        tick(1);
        k = w ? REF_WRITE : (lk ? REF_DREAD_LOCK : REF_DREAD);
        seen.delete();
        op_write = w; op_interlock = lk; op_aligned_only = ao;
        op_addr = a; op_len = n; op_src = dsrc_e'(a[1:0]); op_valid = 1'b1;
        for (i = 0; i < 200 && op_ready !== 1'b1; i++) tick(1);
        op_valid = 1'b0;
        chk("op_ready", 1, op_ready);
        chk("align_fault", ao, align_fault);
        q = {a[31:3], 3'h0};
        for (i = 0; !ao && q < a + n; i++) begin
            for (b = 0; b < 8; b++) en[b] = (q + b >= a) && (q + b < a + n);
            chk("ref", {k, q, en, en != 8'hff}, seen[i]);
            q += 8;
        end
        chk("ref_count", i, seen.size());
    endtask : op
    task automatic complete_run;
        $display("Checks made %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1; preg_wr = 1'b0; preg_rd = 1'b0; preg_addr = 8'h0;
        preg_wdata = 32'h0; trap_start = 1'b0; instr_valid = 1'b0;
        instr_class = OPC_OTHER; pq_used = 3'h4; pq_halted = 1'b0;
        op_valid = 1'b0; op_write = 1'b0; op_interlock = 1'b0;
        op_aligned_only = 1'b0; op_src = DSRC_OPERAND; op_addr = 32'h0;
        op_len = 8'h0; coproc_xfer = 1'b0; wait_cycles = 4'h0;
        tick(2);
        rst = 1'b0;
        reg_rd(8'h28); chk("ctrl_reset", 0, rd);
        reg_wr(8'h28, 32'hffffffff);
        reg_rd(8'h28); chk("ctrl_read", 32'h2, rd);
        reg_wr(8'h10, 32'hffffffff);
        reg_rd(8'h10); chk("unmapped", 0, rd);
        reg_wr(8'h28, 32'h80000002); tick(1);
        chk("ref_bad_parity", 1, ref_bad_parity);
        coproc_xfer = 1'b1; tick(1); coproc_xfer = 1'b0;
        chk("coproc_bad_parity", 1, coproc_bad_parity);
        trap_start = 1'b1; tick(1); trap_start = 1'b0;
        chk("trap_clear", 0, ref_bad_parity);
        reg_wr(8'h28, 32'h80000002); reg_rd(8'h28); tick(1);
        chk("read_clear", 0, ref_bad_parity);
        for (int e = 0; e < 2; e++) begin
            reg_wr(8'h28, {30'h0, e[0], 1'b0});
            instr_valid = 1'b1;
            for (int c = 0; c < 3; c++) begin
                instr_class = opc_class_e'(c);
                tick(1);
                chk("dispatch", e != 0 && c != 0, coproc_dispatch);
                chk("resv_fault", e == 0 && c == 1, resv_instr_fault);
                chk("mull_microcode", e == 0 && c == 2, mull_microcode);
            end
            instr_valid = 1'b0;
        end
        op(1'b0, 1'b0, 1'b0, 32'h106, 8'h1);
        op(1'b0, 1'b1, 1'b0, 32'h7, 8'h2);
        op(1'b1, 1'b0, 1'b0, 32'h8, 8'h8);
        wait_cycles = 4'h2;
        op(1'b1, 1'b0, 1'b0, 32'h3, 8'h8);
        wait_cycles = 4'h3;
        op(1'b0, 1'b0, 1'b0, 32'h4, 8'h14);
        op(1'b1, 1'b0, 1'b0, 32'h1c, 8'hc);
        op(1'b0, 1'b0, 1'b1, 32'h1, 8'h2);
        wait_cycles = 4'h0;
        seen.delete(); pq_used = 3'h3; tick(8); pq_used = 3'h4; tick(8);
        chk("fetch0", {REF_ISTREAM, 32'h0, 8'hff, 1'b0}, seen[0]);
        chk("fetch1", {REF_ISTREAM, 32'h8, 8'hff, 1'b0}, seen[1]);
        seen.delete(); pq_halted = 1'b1; pq_used = 3'h0; tick(8);
        chk("fetch_halted", 0, seen.size());
        complete_run();
    end
endmodule : test_quadword_reference_accel_ctrl
